// ---- verilog/bmc_regs.svh ----
// register map, field positions, reset values and timing counts
`ifndef BMC_REGS_SVH
`define BMC_REGS_SVH
// ************
// addresses
// ************
`define BMC_ADDR_CTRL 5'h00
`define BMC_ADDR_VENDOR 5'h1F
// ************
// reset values
// ************
`define BMC_CTRL_RESET 16'h3100
`define BMC_VENDOR_RESET 16'h0000
// ************
// field positions
// ************
`define BMC_B_SRST 15
`define BMC_B_LB 14
`define BMC_B_SPD 13
`define BMC_B_AN_EN 12
`define BMC_B_PD 11
`define BMC_B_ISO 10
`define BMC_B_AN_RST 9
`define BMC_B_DUP 8
`define BMC_B_COLT 7
// ************
// timing
// ************
`define BMC_CLK_NS 100
`define BMC_SRST_NS 1600
`define BMC_SRST_CYC ((`BMC_SRST_NS + `BMC_CLK_NS - 1) / `BMC_CLK_NS)
`define BMC_SRST_CNT_W 5
`define BMC_BIT_NS 100
`define BMC_COL_ON_BITS 512
`define BMC_COL_ON_CYC ((`BMC_COL_ON_BITS * `BMC_BIT_NS) / `BMC_CLK_NS)
`define BMC_COL_OFF_BITS 4
`define BMC_COL_OFF_CYC ((`BMC_COL_OFF_BITS * `BMC_BIT_NS) / `BMC_CLK_NS)
`endif

// ---- verilog/bmc_pkg.sv ----
// types and field helpers of the basic mode control block
package bmc_pkg;
  `include "bmc_regs.svh"
  typedef enum logic {BMC_RUN, BMC_SRST} bmc_fsm_t;
  typedef struct packed {
    logic srst;
    logic lb;
    logic spd;
    logic an_en;
    logic pd;
    logic iso;
    logic an_rst;
    logic dup;
    logic colt;
  } bmc_ctrl_t;
  typedef struct packed {
    logic tx_en;
    logic [1:0] txd;
  } bmc_rmii_tx_t;
  typedef struct packed {
    logic crs_dv;
    logic [1:0] rxd;
  } bmc_rmii_rx_t;
  typedef struct packed {
    bmc_fsm_t fsm;
    bmc_ctrl_t ctrl;
    logic [15:0] vendor;
    logic [`BMC_SRST_CNT_W-1:0] cnt;
    logic [15:0] rdata;
    bmc_rmii_rx_t rx;
    bmc_rmii_tx_t tx;
    logic col;
    logic an_go;
  } bmc_state_t;
  function automatic bmc_ctrl_t bmc_word_to_ctrl(input logic [15:0] w);
    bmc_ctrl_t c;
    c.srst = w[`BMC_B_SRST];
    c.lb = w[`BMC_B_LB];
    c.spd = w[`BMC_B_SPD];
    c.an_en = w[`BMC_B_AN_EN];
    c.pd = w[`BMC_B_PD];
    c.iso = w[`BMC_B_ISO];
    c.an_rst = w[`BMC_B_AN_RST];
    c.dup = w[`BMC_B_DUP];
    c.colt = w[`BMC_B_COLT];
    return c;
  endfunction
  function automatic logic [15:0] bmc_ctrl_to_word(input bmc_ctrl_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[`BMC_B_SRST] = c.srst;
    w[`BMC_B_LB] = c.lb;
    w[`BMC_B_SPD] = c.spd;
    w[`BMC_B_AN_EN] = c.an_en;
    w[`BMC_B_PD] = c.pd;
    w[`BMC_B_ISO] = c.iso;
    w[`BMC_B_AN_RST] = c.an_rst;
    w[`BMC_B_DUP] = c.dup;
    w[`BMC_B_COLT] = c.colt;
    return w;
  endfunction
endpackage

// ---- verilog/bmc_top.sv ----
// basic mode control register with its control effects on the MAC side
`timescale 1ns/1ns
module bmc_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  input wire logic irq_powerdown_pin_n,
  input wire logic rmii_master,
  input wire bmc_pkg::bmc_rmii_tx_t mac_tx,
  output bmc_pkg::bmc_rmii_rx_t mac_rx,
  output logic col,
  output logic ref_clk_en,
  output bmc_pkg::bmc_rmii_tx_t line_tx,
  input wire bmc_pkg::bmc_rmii_rx_t line_rx,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic an_started,
  output logic an_restart,
  output logic an_enable,
  output logic pcs_reset,
  output logic powered_down,
  output logic speed_100,
  output logic full_duplex
);
  import bmc_pkg::*;

  localparam int SRST_MAX = `BMC_SRST_CYC + 1;
  localparam int COL_ON_MAX = `BMC_COL_ON_CYC;
  localparam int COL_OFF_MAX = `BMC_COL_OFF_CYC;
  localparam logic [`BMC_SRST_CNT_W-1:0] SRST_LOAD = `BMC_SRST_CNT_W'(`BMC_SRST_CYC - 1);

  bmc_state_t q;
  bmc_state_t d;

  logic wr_ctrl;
  logic wr_vendor;
  logic pd_eff;
  logic active;
  bmc_ctrl_t wr_c;

  // ************
  // decode
  // ************
  assign wr_ctrl = mgmt_wr && (mgmt_addr == `BMC_ADDR_CTRL);
  assign wr_vendor = mgmt_wr && (mgmt_addr == `BMC_ADDR_VENDOR);
  assign wr_c = bmc_word_to_ctrl(mgmt_wdata);
  assign pd_eff = q.ctrl.pd || !irq_powerdown_pin_n;
  assign active = !pd_eff && !q.ctrl.iso;

  // ************
  // next state
  // ************
  always_comb begin
    d = q;
    d.an_go = 1'b0;
    if (mgmt_rd) begin
      case (mgmt_addr)
        `BMC_ADDR_CTRL: d.rdata = bmc_ctrl_to_word(q.ctrl);
        `BMC_ADDR_VENDOR: d.rdata = q.vendor;
        default: d.rdata = 16'h0000;
      endcase
    end
    if (wr_vendor) begin
      d.vendor = mgmt_wdata;
    end
    case (q.fsm)
      BMC_RUN: begin
        if (q.ctrl.an_rst && an_started) begin
          d.ctrl.an_rst = 1'b0;
        end
        if (wr_ctrl && wr_c.srst) begin
          d.fsm = BMC_SRST;
          d.cnt = SRST_LOAD;
          d.ctrl = bmc_word_to_ctrl(`BMC_CTRL_RESET);
          d.ctrl.srst = 1'b1;
        end else if (wr_ctrl) begin
          d.ctrl.lb = wr_c.lb;
          d.ctrl.spd = wr_c.spd;
          d.ctrl.an_en = wr_c.an_en;
          d.ctrl.pd = wr_c.pd;
          d.ctrl.iso = wr_c.iso;
          d.ctrl.dup = wr_c.dup;
          d.ctrl.colt = wr_c.colt;
          if (wr_c.an_rst && wr_c.an_en) begin
            d.ctrl.an_rst = 1'b1;
            d.an_go = 1'b1;
          end else if (!wr_c.an_rst) begin
            // clearing only drops the flag, negotiation runs on
            d.ctrl.an_rst = 1'b0;
          end else begin
            d.ctrl.an_rst = 1'b0;
          end
        end
      end
      BMC_SRST: begin
        // vendor register is left as it is
        if (q.cnt == '0) begin
          d.fsm = BMC_RUN;
          d.ctrl.srst = 1'b0;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      default: begin
        d.fsm = BMC_RUN;
      end
    endcase
    if (!irq_powerdown_pin_n) begin
      d.ctrl.pd = 1'b1;
    end
    // data paths, quiet while powered down or isolated
    d.rx = '0;
    d.tx = '0;
    d.col = 1'b0;
    if (active) begin
      if (q.ctrl.lb) begin
        d.rx.crs_dv = mac_tx.tx_en;
        d.rx.rxd = mac_tx.txd;
      end else begin
        d.rx = line_rx;
        d.tx = mac_tx;
      end
      d.col = q.ctrl.colt && mac_tx.tx_en;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q.fsm <= BMC_RUN;
      q.ctrl <= bmc_word_to_ctrl(`BMC_CTRL_RESET);
      q.vendor <= `BMC_VENDOR_RESET;
      q.cnt <= '0;
      q.rdata <= 16'h0000;
      q.rx <= '0;
      q.tx <= '0;
      q.col <= 1'b0;
      q.an_go <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ************
  // outputs
  // ************
  assign mgmt_rdata = q.rdata;
  assign mac_rx = q.rx;
  assign line_tx = q.tx;
  assign col = q.col;
  assign an_restart = q.an_go;
  assign an_enable = q.ctrl.an_en;
  assign pcs_reset = q.ctrl.srst;
  assign powered_down = pd_eff;
  assign ref_clk_en = !(q.ctrl.iso && rmii_master);
  assign speed_100 = q.ctrl.an_en ? an_speed_100 : q.ctrl.spd;
  assign full_duplex = q.ctrl.an_en ? an_full_duplex : q.ctrl.dup;

  // ************
  // checks
  // ************
  AST_SRST_DONE: assert property (@(posedge core_clk) disable iff (!nrst)
    q.ctrl.srst |-> ##[1:SRST_MAX] !q.ctrl.srst)
    else $error("software reset bit did not clear");

  AST_SRST_VALUES: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_ctrl && wr_c.srst && q.fsm == BMC_RUN)
    |=> q.ctrl.an_en && q.ctrl.spd && q.ctrl.dup && !q.ctrl.lb && !q.ctrl.iso && !q.ctrl.colt)
    else $error("software reset did not restore defaults");

  AST_VENDOR_KEEP: assert property (@(posedge core_clk) disable iff (!nrst)
    (q.fsm == BMC_SRST && !wr_vendor) |=> $stable(q.vendor))
    else $error("vendor register changed by software reset");

  AST_LOOPBACK: assert property (@(posedge core_clk) disable iff (!nrst)
    (active && q.ctrl.lb)
    |=> mac_rx.rxd == $past(mac_tx.txd) && mac_rx.crs_dv == $past(mac_tx.tx_en) && line_tx == '0)
    else $error("loopback data mismatch");

  AST_FORCED_MODE: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_ctrl && !wr_c.srst && !wr_c.an_en && q.fsm == BMC_RUN)
    |=> speed_100 == $past(mgmt_wdata[`BMC_B_SPD]) && full_duplex == $past(mgmt_wdata[`BMC_B_DUP]))
    else $error("forced speed or duplex not applied");

  AST_AN_MODE: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_ctrl && !wr_c.srst && wr_c.an_en && q.fsm == BMC_RUN)
    |=> speed_100 == an_speed_100 && full_duplex == an_full_duplex)
    else $error("negotiated mode not followed");

  AST_PD_PIN: assert property (@(posedge core_clk) disable iff (!nrst)
    !irq_powerdown_pin_n |=> q.ctrl.pd && powered_down)
    else $error("power-down pin did not set the bit");

  AST_PD_QUIET: assert property (@(posedge core_clk) disable iff (!nrst)
    (pd_eff || q.ctrl.iso) |=> mac_rx == '0 && line_tx == '0 && !col)
    else $error("data path active while down or isolated");

  AST_ISO_CLK: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_ctrl && wr_c.iso && !wr_c.srst && q.fsm == BMC_RUN)
    |=> (ref_clk_en == !rmii_master))
    else $error("reference clock not stopped in isolate");

  AST_RST_IGNORE: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_ctrl && wr_c.an_rst && !wr_c.an_en && !wr_c.srst && q.fsm == BMC_RUN)
    |=> !q.ctrl.an_rst && !an_restart)
    else $error("restart accepted with negotiation off");

  AST_RST_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    (q.ctrl.an_rst && !an_started && !wr_ctrl && q.fsm == BMC_RUN) |=> q.ctrl.an_rst)
    else $error("restart bit cleared before start");

  AST_RST_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_ctrl && !wr_c.an_rst && !wr_c.srst && q.fsm == BMC_RUN) |=> !an_restart && !q.ctrl.an_rst)
    else $error("clearing restart disturbed negotiation");

  AST_COL_ON: assert property (@(posedge core_clk) disable iff (!nrst)
    (active && q.ctrl.colt && mac_tx.tx_en) |-> ##[1:COL_ON_MAX] col)
    else $error("collision test COL late");

  AST_COL_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
    (col && !mac_tx.tx_en) |-> ##[1:COL_OFF_MAX] !col)
    else $error("collision test COL not dropped");

  AST_RSVD: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(mgmt_rd && mgmt_addr == `BMC_ADDR_CTRL) |-> mgmt_rdata[6:0] == 7'h00)
    else $error("reserved bits not zero");

endmodule

// ---- testbench/bmc_partner.sv ----
// negotiation engine and coding sublayer model on the far side of the block
`timescale 1ns/1ns
module bmc_partner (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic an_restart,
  output logic an_started,
  output logic an_speed_100,
  output logic an_full_duplex,
  output bmc_pkg::bmc_rmii_rx_t line_rx
);
  import bmc_pkg::*;
  logic [3:0] dly_q;
  logic [2:0] pat_q;
  // ************
  // restart answer after a slow start, receive pattern changing every cycle
  // ************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dly_q <= 4'h0;
      pat_q <= 3'h0;
    end else begin
      pat_q <= pat_q + 3'h1;
      if (an_restart) begin
        dly_q <= 4'h8;
      end else if (dly_q != 4'h0) begin
        dly_q <= dly_q - 4'h1;
      end
    end
  end
  assign an_started = (dly_q == 4'h1);
  assign an_speed_100 = 1'b1;
  assign an_full_duplex = 1'b0;
  assign line_rx = bmc_rmii_rx_t'(pat_q);
endmodule

// ---- testbench/phy_basic_mode_control_tb.sv ----
// self-checking bench of the basic mode control block
`timescale 1ns/1ns
module phy_basic_mode_control_tb;
  import bmc_pkg::*;
  logic core_clk, nrst, mgmt_wr, mgmt_rd, pin_n, rmii_master;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, e;
  bmc_rmii_tx_t mac_tx, line_tx;
  bmc_rmii_rx_t mac_rx, line_rx;
  logic col, ref_clk_en, an_speed_100, an_full_duplex, an_started, an_restart;
  logic an_enable, pcs_reset, powered_down, speed_100, full_duplex;
  int err_count, cmp_count;
  logic [15:0] words [3] = '{16'h2000, 16'h0100, 16'h0000};
  bmc_top DUT (.core_clk(core_clk), .nrst(nrst), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .irq_powerdown_pin_n(pin_n), .rmii_master(rmii_master), .mac_tx(mac_tx), .mac_rx(mac_rx),
    .col(col), .ref_clk_en(ref_clk_en), .line_tx(line_tx), .line_rx(line_rx),
    .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex), .an_started(an_started),
    .an_restart(an_restart), .an_enable(an_enable), .pcs_reset(pcs_reset),
    .powered_down(powered_down), .speed_100(speed_100), .full_duplex(full_duplex));
  bmc_partner partner (.core_clk(core_clk), .nrst(nrst), .an_restart(an_restart),
    .an_started(an_started), .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
    .line_rx(line_rx));
  // ************
  // tasks
  // ************
  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] got);
    cmp_count++;
    if (got !== ex) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    mgmt_wr <= 1'b1;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    @(posedge core_clk);
    mgmt_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] ex);
    @(posedge core_clk);
    mgmt_rd <= 1'b1;
    mgmt_addr <= a;
    @(posedge core_clk);
    mgmt_rd <= 1'b0;
    #1;
    chk("mgmt_rdata", ex, mgmt_rdata);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return pcs_reset;
      1: return col;
      default: return an_started;
    endcase
  endfunction
  task automatic waitv(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(w) !== v && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (sig(w) !== v) begin
      err_count++;
      $display("ERROR wait %0d expected %b seen %b", w, v, sig(w));
      summarize();
    end
  endtask
  // ************
  // clock, reset, sequence
  // ************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    nrst = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_addr = 5'h00;
    mgmt_wdata = 16'h0000;
    pin_n = 1'b1;
    rmii_master = 1'b1;
    mac_tx = bmc_rmii_tx_t'(3'h0);
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    rd(5'h00, 16'h3100);
    rd(5'h1F, 16'h0000);
    rd(5'h05, 16'h0000);
    wr(5'h1F, 16'hA5A5);
    wr(5'h00, 16'h8000);
    chk("pcs_reset", 16'h0001, pcs_reset);
    wr(5'h00, 16'h0000);
    waitv(0, 1'b0, 20);
    rd(5'h00, 16'h3100);
    rd(5'h1F, 16'hA5A5);
    wr(5'h05, 16'hFFFF);
    wr(5'h00, 16'h007F);
    rd(5'h00, 16'h0000);
    rd(5'h05, 16'h0000);
    foreach (words[i]) begin
      wr(5'h00, words[i]);
      chk("speed_100", {15'h0000, words[i][13]}, speed_100);
      chk("full_duplex", {15'h0000, words[i][8]}, full_duplex);
    end
    wr(5'h00, 16'h0200);
    chk("an_restart", 16'h0000, an_restart);
    rd(5'h00, 16'h0000);
    wr(5'h00, 16'h1200);
    chk("an_restart", 16'h0001, an_restart);
    chk("an_enable", 16'h0001, an_enable);
    chk("speed_100", 16'h0001, speed_100);
    chk("full_duplex", 16'h0000, full_duplex);
    rd(5'h00, 16'h1200);
    waitv(2, 1'b1, 20);
    repeat (2) @(posedge core_clk);
    rd(5'h00, 16'h1000);
    e = {13'h0000, line_rx};
    @(posedge core_clk);
    #1;
    chk("mac_rx", e, {13'h0000, mac_rx});
    wr(5'h16, 16'h0001);
    wr(5'h00, 16'h4000);
    mac_tx <= bmc_rmii_tx_t'(3'h6);
    repeat (2) @(posedge core_clk);
    #1;
    chk("mac_rx", 16'h0006, {13'h0000, mac_rx});
    chk("line_tx", 16'h0000, {13'h0000, line_tx});
    wr(5'h00, 16'h0400);
    chk("ref_clk_en", 16'h0000, ref_clk_en);
    @(posedge core_clk);
    rmii_master <= 1'b0;
    #1;
    chk("mac_rx", 16'h0000, {13'h0000, mac_rx});
    chk("ref_clk_en", 16'h0001, ref_clk_en);
    wr(5'h00, 16'h0000);
    pin_n <= 1'b0;
    @(posedge core_clk);
    pin_n <= 1'b1;
    #1;
    chk("powered_down", 16'h0001, powered_down);
    rd(5'h00, 16'h0800);
    chk("line_tx", 16'h0000, {13'h0000, line_tx});
    wr(5'h00, 16'h0080);
    chk("powered_down", 16'h0000, powered_down);
    mac_tx <= bmc_rmii_tx_t'(3'h0);
    @(posedge core_clk);
    mac_tx <= bmc_rmii_tx_t'(3'h4);
    waitv(1, 1'b1, 512);
    @(posedge core_clk);
    mac_tx <= bmc_rmii_tx_t'(3'h0);
    waitv(1, 1'b0, 4);
    summarize();
  end
endmodule
